// *** core/pcx_ct_device.sv ***
// Memory device end of the pin-continuity test: XOR network from test
// inputs to DQ/strobe pins, plus entry, exit and timing status tracking.
// Assumes the agent end drives all inputs; pins are asynchronous to clk_sys.
//
// Operation
// RULE1 - term0 = A1^A6^PAR, term1 = A8^ALERT_n^A9
// RULE2 - term2 = A2^A5^A13, plus A17 if present
// RULE3 - term3 = A0^A7^A11, term5 = CKE^A16^A10
// RULE4 - term4 = CK_c^ODT^A15, term6 = ACT_n^A4^BA1
// RULE5 - term7 depends on data width
// RULE6 - term8 = A14^A12^BA0, term9 = BG0^A3^(RESET_n&TEN)
// RULE7 - x4: DQ pairs XOR terms, strobes 8/9
// RULE8 - x8: DQ equals term, strobes 8/9
// RULE9 - x16: upper half inverts lower half
// RULE10 - agent holds RESET_n, CKE, CS_n high entering
// RULE11 - clock pins become test inputs after delay
// RULE12 - other inputs accepted after enable delay
// RULE13 - no refresh of any kind in test
// RULE14 - test only after power-on, before calibration
// RULE15 - TEN may drop anytime; reset then needed
// RULE16 - outputs stable within settle time
// RULE17 - TEN high bypasses core, reference at half
// RULE18 - drivers on only while CS_n low
// RULE19 - TEN kept low in normal operation
// RULE20 - output network purely combinational
`timescale 1ns/1ps
`default_nettype none
module pcx_ct_device #(
  parameter int DQ_WIDTH = pcx_pkg::WIDTH_X8,
  parameter bit HAS_A17 = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Pins
  pcx_ct_if.dev pins,
  // Core-side refresh requests
  input wire logic auto_refresh_req,
  input wire logic self_refresh_req,
  // Status toward the memory core
  output logic ct_mode_q,
  output logic clk_inputs_test_q,
  output logic inputs_accepted_q,
  output logic outputs_stable_q,
  output logic vref_half_q,
  output logic core_bypass_q,
  output logic refresh_go_q,
  output logic self_refresh_go_q,
  output logic entry_fault_q,
  output logic reinit_required_q
);

  // Refuse widths the mapping cannot serve, at elaboration
  if (DQ_WIDTH != pcx_pkg::WIDTH_X4 && DQ_WIDTH != pcx_pkg::WIDTH_X8 &&
      DQ_WIDTH != pcx_pkg::WIDTH_X16) begin : g_bad_width
    $error("pcx_ct_device: DQ_WIDTH must be 4, 8 or 16");
  end

  logic [9:0] xor_term;
  logic drive_en;
  logic a17_bit;

  // A17 only exists on larger densities
  assign a17_bit = HAS_A17 ? pins.addr[17] : 1'b0;

  // Minimum terms straight from pin levels, no clock involved [RULE20]
  always_comb begin
    xor_term[0] = pins.addr[1] ^ pins.addr[6] ^ pins.par; // [RULE1]
    xor_term[1] = pins.addr[8] ^ pins.alert_n ^ pins.addr[9]; // [RULE1]
    xor_term[2] = pins.addr[2] ^ pins.addr[5] ^ pins.addr[13] ^ a17_bit; // [RULE2]
    xor_term[3] = pins.addr[0] ^ pins.addr[7] ^ pins.addr[11]; // [RULE3]
    xor_term[4] = pins.ck_c ^ pins.odt ^ pins.addr[15]; // [RULE4]
    xor_term[5] = pins.cke ^ pins.addr[16] ^ pins.addr[10]; // [RULE3]
    xor_term[6] = pins.act_n ^ pins.addr[4] ^ pins.ba[1]; // [RULE4]
    // Width picks which mask or group pin joins the clock [RULE5]
    if (DQ_WIDTH == pcx_pkg::WIDTH_X16) begin
      xor_term[7] = pins.dm_u_n ^ pins.dm_l_n ^ pins.ck_t;
    end else if (DQ_WIDTH == pcx_pkg::WIDTH_X8) begin
      xor_term[7] = pins.bg[1] ^ pins.dm_l_n ^ pins.ck_t;
    end else begin
      xor_term[7] = pins.bg[1] ^ pins.ck_t;
    end
    xor_term[8] = pins.addr[14] ^ pins.addr[12] ^ pins.ba[0]; // [RULE6]
    xor_term[9] = pins.bg[0] ^ pins.addr[3] ^ (pins.reset_n & pins.ten); // [RULE6]
  end

  // Drivers only while in test mode with chip select low [RULE17] [RULE18]
  assign drive_en = pins.ten & ~pins.cs_n;

  // Per-bit DQ mapping; bits above the width stay undriven
  for (genvar i = 0; i < pcx_pkg::DQ_MAX; i++) begin : g_dq
    if (DQ_WIDTH == pcx_pkg::WIDTH_X4 && i < pcx_pkg::WIDTH_X4) begin : g_x4
      assign pins.dq_o[i] = xor_term[2 * i] ^ xor_term[2 * i + 1]; // [RULE7]
      assign pins.dq_oe[i] = drive_en;
    end else if (DQ_WIDTH == pcx_pkg::WIDTH_X8 && i < pcx_pkg::WIDTH_X8) begin : g_x8
      assign pins.dq_o[i] = xor_term[i]; // [RULE8]
      assign pins.dq_oe[i] = drive_en;
    end else if (DQ_WIDTH == pcx_pkg::WIDTH_X16 && i < pcx_pkg::WIDTH_X8) begin : g_lo
      assign pins.dq_o[i] = xor_term[i]; // [RULE9]
      assign pins.dq_oe[i] = drive_en;
    end else if (DQ_WIDTH == pcx_pkg::WIDTH_X16) begin : g_hi
      assign pins.dq_o[i] = ~xor_term[i - pcx_pkg::WIDTH_X8]; // [RULE9]
      assign pins.dq_oe[i] = drive_en;
    end else begin : g_off
      assign pins.dq_o[i] = 1'b0;
      assign pins.dq_oe[i] = 1'b0;
    end
  end

  // Strobes carry terms 8 and 9 at every width [RULE7] [RULE8] [RULE9]
  assign pins.dqs_t_o = xor_term[8];
  assign pins.dqs_c_o = xor_term[9];
  assign pins.dqs_oe = drive_en;
  // Upper strobes exist only on x16 and mirror the lower ones inverted [RULE9]
  assign pins.udqs_t_o = ~xor_term[8];
  assign pins.udqs_c_o = ~xor_term[9];
  assign pins.udqs_oe = drive_en & (DQ_WIDTH == pcx_pkg::WIDTH_X16);

  // Control pins pass two flops before any status logic reads them
  logic [3:0] ctl_raw;
  logic [3:0] ctl_meta_q;
  logic [3:0] ctl_sync_q;
  assign ctl_raw = {pins.ten, pins.cs_n, pins.reset_n, pins.cke};

  for (genvar s = 0; s < 4; s++) begin : g_sync
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        ctl_meta_q[s] <= 1'b0;
        ctl_sync_q[s] <= 1'b0;
      end else begin
        ctl_meta_q[s] <= ctl_raw[s];
        ctl_sync_q[s] <= ctl_meta_q[s];
      end
    end
  end

  logic ten_s;
  logic cs_n_s;
  logic reset_n_s;
  logic cke_s;
  logic ten_prev_q;
  logic ten_rise;
  logic ten_fall;
  assign {ten_s, cs_n_s, reset_n_s, cke_s} = ctl_sync_q;
  assign ten_rise = ten_s & ~ten_prev_q;
  assign ten_fall = ~ten_s & ten_prev_q;

  // Edge history of the synchronised enable
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ten_prev_q <= 1'b0;
    end else begin
      ten_prev_q <= ten_s;
    end
  end

  // Test mode follows TEN; exit is allowed at any moment [RULE15] [RULE17]
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ct_mode_q <= 1'b0;
    end else if (!ten_s) begin
      ct_mode_q <= 1'b0;
    end else if (ten_rise) begin
      ct_mode_q <= 1'b1;
    end
  end

  // Entry with RESET_n, CKE or CS_n low is flagged, not blocked [RULE10]
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      entry_fault_q <= 1'b0;
    end else if (ten_rise && !(reset_n_s && cke_s && cs_n_s)) begin
      entry_fault_q <= 1'b1;
    end else if (!ten_s) begin
      entry_fault_q <= 1'b0;
    end
  end

  // Clock pins turn into test inputs after a fixed delay [RULE11]
  logic [pcx_pkg::CNT_W-1:0] clk_cnt_q;
  always_ff @(posedge clk_sys) begin
    if (srst || !ten_s) begin
      clk_cnt_q <= '0;
      clk_inputs_test_q <= 1'b0;
    end else if (clk_cnt_q == pcx_pkg::CNT_W'(pcx_pkg::CLOCK_VALID_CYC - 1)) begin
      clk_inputs_test_q <= 1'b1;
    end else begin
      clk_cnt_q <= clk_cnt_q + 1'b1;
    end
  end

  // Remaining inputs accepted once CS_n low cycles since TEN rose add up to the enable delay [RULE12]
  logic [pcx_pkg::CNT_W-1:0] en_cnt_q;
  always_ff @(posedge clk_sys) begin
    if (srst || !ten_s) begin
      en_cnt_q <= '0;
      inputs_accepted_q <= 1'b0;
    end else if (en_cnt_q == pcx_pkg::CNT_W'(pcx_pkg::INPUT_ENABLE_CYC - 1)) begin
      inputs_accepted_q <= 1'b1;
    end else if (!cs_n_s) begin
      en_cnt_q <= en_cnt_q + 1'b1;
    end
  end

  // Settle window restarts whenever drivers drop; the network itself is
  // combinational, so this only reports when results may be trusted [RULE16]
  logic [pcx_pkg::CNT_W-1:0] settle_cnt_q;
  always_ff @(posedge clk_sys) begin
    if (srst || !ten_s || cs_n_s || !inputs_accepted_q) begin
      settle_cnt_q <= '0;
      outputs_stable_q <= 1'b0;
    end else if (settle_cnt_q == pcx_pkg::CNT_W'(pcx_pkg::OUTPUT_SETTLE_CYC - 1)) begin
      outputs_stable_q <= 1'b1;
    end else begin
      settle_cnt_q <= settle_cnt_q + 1'b1;
    end
  end

  // Reference at half supply and core bypass track the test mode [RULE17]
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      vref_half_q <= 1'b0;
      core_bypass_q <= 1'b0;
    end else begin
      vref_half_q <= ten_s;
      core_bypass_q <= ten_s;
    end
  end

  // Refresh of either kind is suppressed while TEN is high [RULE13]
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      refresh_go_q <= 1'b0;
      self_refresh_go_q <= 1'b0;
    end else begin
      refresh_go_q <= auto_refresh_req & ~ten_s & ~ct_mode_q;
      self_refresh_go_q <= self_refresh_req & ~ten_s & ~ct_mode_q;
    end
  end

  // Array state is lost on exit until RESET_n is pulled low; set wins [RULE15]
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reinit_required_q <= 1'b0;
    end else if (ten_fall) begin
      reinit_required_q <= 1'b1;
    end else if (!reset_n_s && !ten_s) begin
      reinit_required_q <= 1'b0;
    end
  end

endmodule : pcx_ct_device
`default_nettype wire

// *** core/pcx_pkg.sv ***
// Shared constants for the pin-continuity test block: timing, widths,
// pattern field positions and the test agent's states.
// Assumes both ends run on clk_sys at 40 MHz.
package pcx_pkg;

  // Clock period in picoseconds (40 MHz)
  localparam int CLK_PERIOD_PS = 25000;

  // Test-mode times in ns; plain defaults, tune them to the part in use
  localparam int OUTPUT_SETTLE_TIME_NS = 200;
  localparam int INPUT_ENABLE_DELAY_NS = 200;
  localparam int CLOCK_INPUT_VALID_DELAY_NS = 100;
  localparam int RESET_HOLD_NS = 200;

  // Least times round up to whole cycles
  localparam int OUTPUT_SETTLE_CYC = (OUTPUT_SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                     / CLK_PERIOD_PS;
  localparam int INPUT_ENABLE_CYC = (INPUT_ENABLE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;
  localparam int CLOCK_VALID_CYC = (CLOCK_INPUT_VALID_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Counter width for all of the above
  localparam int CNT_W = 8;

  // Supported data widths
  localparam int WIDTH_X4 = 4;
  localparam int WIDTH_X8 = 8;
  localparam int WIDTH_X16 = 16;
  localparam int DQ_MAX = 16;
  localparam int ADDR_W = 18;

  // Bit positions in the control pattern word
  localparam int CTL_W = 9;
  localparam int CTL_CKE = 0;
  localparam int CTL_ACT_N = 1;
  localparam int CTL_ODT = 2;
  localparam int CTL_PAR = 3;
  localparam int CTL_ALERT_N = 4;
  localparam int CTL_CK_T = 5;
  localparam int CTL_CK_C = 6;
  localparam int CTL_DM_L_N = 7;
  localparam int CTL_DM_U_N = 8;

  // Strobe result positions
  localparam int DQS_T = 0;
  localparam int DQS_C = 1;
  localparam int UDQS_T = 2;
  localparam int UDQS_C = 3;

  // Test agent sequence
  typedef enum logic [2:0] {
    AG_IDLE = 3'h0,
    AG_ENTRY = 3'h1,
    AG_SELECT = 3'h2,
    AG_APPLY = 3'h3,
    AG_READY = 3'h4,
    AG_RESET = 3'h5
  } pcx_agent_state_type;

endpackage : pcx_pkg

// *** core/pcx_ct_if.sv ***
// Pin bundle between the memory device's test port and the board agent.
// Two-way data pins appear as value plus enable; the bench resolves them.
`timescale 1ns/1ps
`default_nettype none
interface pcx_ct_if;
  // Agent-driven pins
  logic ten;
  logic cs_n;
  logic reset_n;
  logic cke;
  logic act_n;
  logic odt;
  logic par;
  logic alert_n;
  logic ck_t;
  logic ck_c;
  logic [17:0] addr;
  logic [1:0] ba;
  logic [1:0] bg;
  logic dm_l_n;
  logic dm_u_n;
  // Device-driven pins
  logic [15:0] dq_o;
  logic [15:0] dq_oe;
  logic dqs_t_o;
  logic dqs_c_o;
  logic dqs_oe;
  logic udqs_t_o;
  logic udqs_c_o;
  logic udqs_oe;

  modport dev (
    input ten, cs_n, reset_n, cke, act_n, odt, par, alert_n, ck_t, ck_c,
    input addr, ba, bg, dm_l_n, dm_u_n,
    output dq_o, dq_oe, dqs_t_o, dqs_c_o, dqs_oe, udqs_t_o, udqs_c_o, udqs_oe
  );

  modport agent (
    output ten, cs_n, reset_n, cke, act_n, odt, par, alert_n, ck_t, ck_c,
    output addr, ba, bg, dm_l_n, dm_u_n,
    input dq_o, dq_oe, dqs_t_o, dqs_c_o, dqs_oe, udqs_t_o, udqs_c_o, udqs_oe
  );
endinterface : pcx_ct_if
`default_nettype wire

// *** core/pcx_ct_agent.sv ***
// Board test agent end: enters test mode, applies a pattern in parallel,
// captures DQ/strobe results, and resets the device on exit.
// Assumes the device end on the same pin bundle; results pass two flops.
`timescale 1ns/1ps
`default_nettype none
module pcx_ct_agent #(
  parameter int DQ_WIDTH = pcx_pkg::WIDTH_X8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Pins
  pcx_ct_if.agent pins,
  // System state
  input wire logic power_ok,
  input wire logic device_calibrated,
  // User requests
  input wire logic start,
  input wire logic exit_req,
  input wire logic [pcx_pkg::ADDR_W-1:0] pat_addr,
  input wire logic [1:0] pat_ba,
  input wire logic [1:0] pat_bg,
  input wire logic [pcx_pkg::CTL_W-1:0] pat_ctl,
  // User results
  output logic busy_q,
  output logic done_q,
  output logic refused_q,
  output logic [pcx_pkg::DQ_MAX-1:0] res_dq_q,
  output logic [3:0] res_dqs_q
);

  // Refuse widths the capture cannot serve, at elaboration
  if (DQ_WIDTH != pcx_pkg::WIDTH_X4 && DQ_WIDTH != pcx_pkg::WIDTH_X8 &&
      DQ_WIDTH != pcx_pkg::WIDTH_X16) begin : g_bad_width
    $error("pcx_ct_agent: DQ_WIDTH must be 4, 8 or 16");
  end

  pcx_pkg::pcx_agent_state_type state_q;
  logic [pcx_pkg::CNT_W-1:0] cnt_q;
  logic [pcx_pkg::CNT_W-1:0] wait_len;
  logic [19:0] res_raw;
  logic [19:0] res_meta_q;
  logic [19:0] res_sync_q;
  logic ten_q;
  logic cs_n_q;
  logic reset_n_q;
  logic [pcx_pkg::ADDR_W-1:0] addr_q;
  logic [1:0] ba_q;
  logic [1:0] bg_q;
  logic [pcx_pkg::CTL_W-1:0] ctl_q;
  logic cnt_done;

  // Returned pins pass two flops before capture
  assign res_raw = {pins.udqs_c_o, pins.udqs_t_o, pins.dqs_c_o, pins.dqs_t_o, pins.dq_o};
  for (genvar i = 0; i < 20; i++) begin : g_sync
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        res_meta_q[i] <= 1'b0;
        res_sync_q[i] <= 1'b0;
      end else begin
        res_meta_q[i] <= res_raw[i];
        res_sync_q[i] <= res_meta_q[i];
      end
    end
  end

  // Wait length per state; capture also covers the two sync flops [RULE12] [RULE16]
  always_comb begin
    unique case (state_q)
      pcx_pkg::AG_ENTRY: wait_len = pcx_pkg::CNT_W'(pcx_pkg::CLOCK_VALID_CYC);
      pcx_pkg::AG_SELECT: wait_len = pcx_pkg::CNT_W'(pcx_pkg::INPUT_ENABLE_CYC);
      pcx_pkg::AG_APPLY: wait_len = pcx_pkg::CNT_W'(pcx_pkg::OUTPUT_SETTLE_CYC + 2);
      pcx_pkg::AG_RESET: wait_len = pcx_pkg::CNT_W'(pcx_pkg::RESET_HOLD_CYC);
      default: wait_len = '0;
    endcase
  end
  assign cnt_done = (cnt_q >= wait_len);

  // Sequencer and pin drive
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= pcx_pkg::AG_IDLE;
      cnt_q <= '0;
      ten_q <= 1'b0;
      cs_n_q <= 1'b1;
      reset_n_q <= 1'b1;
      addr_q <= '0;
      ba_q <= '0;
      bg_q <= '0;
      ctl_q <= pcx_pkg::CTL_W'(1 << pcx_pkg::CTL_CKE);
      done_q <= 1'b0;
      refused_q <= 1'b0;
      res_dq_q <= '0;
      res_dqs_q <= '0;
    end else begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
      cnt_q <= cnt_done ? cnt_q : cnt_q + 1'b1;
      unique case (state_q)
        pcx_pkg::AG_IDLE: begin
          ten_q <= 1'b0; // [RULE19]
          cs_n_q <= 1'b1;
          reset_n_q <= 1'b1;
          ctl_q <= pcx_pkg::CTL_W'(1 << pcx_pkg::CTL_CKE);
          if (start && (!power_ok || device_calibrated)) begin
            refused_q <= 1'b1; // [RULE14]
          end else if (start) begin
            ten_q <= 1'b1; // [RULE10]
            cnt_q <= '0;
            state_q <= pcx_pkg::AG_ENTRY;
          end
        end
        pcx_pkg::AG_ENTRY: begin
          if (cnt_done) begin
            cs_n_q <= 1'b0;
            cnt_q <= '0;
            state_q <= pcx_pkg::AG_SELECT;
          end
        end
        pcx_pkg::AG_SELECT: begin
          if (cnt_done) begin
            addr_q <= pat_addr;
            ba_q <= pat_ba;
            bg_q <= pat_bg;
            ctl_q <= pat_ctl;
            cnt_q <= '0;
            state_q <= pcx_pkg::AG_APPLY;
          end
        end
        pcx_pkg::AG_APPLY: begin
          if (cnt_done) begin
            res_dq_q <= res_sync_q[15:0];
            res_dqs_q <= res_sync_q[19:16];
            done_q <= 1'b1;
            state_q <= pcx_pkg::AG_READY;
          end
        end
        pcx_pkg::AG_READY: begin
          if (exit_req) begin
            ten_q <= 1'b0; // [RULE15]
            cs_n_q <= 1'b1;
            reset_n_q <= 1'b0;
            cnt_q <= '0;
            state_q <= pcx_pkg::AG_RESET;
          end else if (start) begin
            addr_q <= pat_addr;
            ba_q <= pat_ba;
            bg_q <= pat_bg;
            ctl_q <= pat_ctl;
            cnt_q <= '0;
            state_q <= pcx_pkg::AG_APPLY;
          end
        end
        pcx_pkg::AG_RESET: begin
          // Full reset pulse, since array state is lost on exit [RULE15]
          if (cnt_done) begin
            reset_n_q <= 1'b1;
            state_q <= pcx_pkg::AG_IDLE;
          end
        end
        default: state_q <= pcx_pkg::AG_IDLE;
      endcase
    end
  end

  // No refresh is ever issued; busy covers the test session except while waiting in AG_READY [RULE13]
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q != pcx_pkg::AG_IDLE) && (state_q != pcx_pkg::AG_READY);
    end
  end

  // Pin drive straight from registers
  assign pins.ten = ten_q;
  assign pins.cs_n = cs_n_q;
  assign pins.reset_n = reset_n_q;
  assign pins.cke = ctl_q[pcx_pkg::CTL_CKE];
  assign pins.act_n = ctl_q[pcx_pkg::CTL_ACT_N];
  assign pins.odt = ctl_q[pcx_pkg::CTL_ODT];
  assign pins.par = ctl_q[pcx_pkg::CTL_PAR];
  assign pins.alert_n = ctl_q[pcx_pkg::CTL_ALERT_N];
  assign pins.ck_t = ctl_q[pcx_pkg::CTL_CK_T];
  assign pins.ck_c = ctl_q[pcx_pkg::CTL_CK_C];
  assign pins.dm_l_n = ctl_q[pcx_pkg::CTL_DM_L_N];
  assign pins.dm_u_n = ctl_q[pcx_pkg::CTL_DM_U_N];
  assign pins.addr = addr_q;
  assign pins.ba = ba_q;
  assign pins.bg = bg_q;

endmodule : pcx_ct_agent
`default_nettype wire

// *** verification/pcx_ct_props.sv ***
// Checker for the pin bundle between the device and agent ends.
// Assumes an x16 device with A17 present; sampled on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pcx_ct_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Agent-driven pins
  input wire logic ten,
  input wire logic cs_n,
  input wire logic reset_n,
  input wire logic cke,
  input wire logic act_n,
  input wire logic odt,
  input wire logic par,
  input wire logic alert_n,
  input wire logic ck_t,
  input wire logic ck_c,
  input wire logic [17:0] addr,
  input wire logic [1:0] ba,
  input wire logic [1:0] bg,
  input wire logic dm_l_n,
  input wire logic dm_u_n,
  // Device-driven pins
  input wire logic [15:0] dq_o,
  input wire logic [15:0] dq_oe,
  input wire logic dqs_t_o,
  input wire logic dqs_c_o,
  input wire logic dqs_oe,
  input wire logic udqs_t_o,
  input wire logic udqs_c_o,
  input wire logic udqs_oe
);
  logic [9:0] t;

  // Reference terms, built apart from the device logic
  always_comb begin
    t[0] = addr[1] ^ addr[6] ^ par;
    t[1] = addr[8] ^ alert_n ^ addr[9];
    t[2] = addr[2] ^ addr[5] ^ addr[13] ^ addr[17];
    t[3] = addr[0] ^ addr[7] ^ addr[11];
    t[4] = ck_c ^ odt ^ addr[15];
    t[5] = cke ^ addr[16] ^ addr[10];
    t[6] = act_n ^ addr[4] ^ ba[1];
    t[7] = dm_u_n ^ dm_l_n ^ ck_t;
    t[8] = addr[14] ^ addr[12] ^ ba[0];
    t[9] = bg[0] ^ addr[3] ^ (reset_n & ten);
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  a_term_zero_one: assert property (ten |-> dq_o[1:0] == t[1:0])
    else $error("dq bits 0 and 1 differ from terms");
  a_term_two_a17: assert property (ten |-> dq_o[2] == t[2])
    else $error("dq bit 2 differs from term");
  a_term_three_five: assert property (ten |-> {dq_o[5], dq_o[3]} == {t[5], t[3]})
    else $error("dq bits 3 or 5 differ from terms");
  a_term_four_six: assert property (ten |-> {dq_o[6], dq_o[4]} == {t[6], t[4]})
    else $error("dq bits 4 or 6 differ from terms");
  a_term_seven_mask: assert property (ten |-> dq_o[7] == t[7])
    else $error("dq bit 7 differs from mask term");
  a_strobe_terms: assert property (ten |-> {dqs_c_o, dqs_t_o} == t[9:8])
    else $error("strobes differ from terms 8 and 9");
  a_upper_inverse: assert property (ten |-> dq_o[15:8] == ~dq_o[7:0]
      && udqs_t_o == !dqs_t_o && udqs_c_o == !dqs_c_o)
    else $error("upper byte not the inverse of lower");
  a_drive_select: assert property (ten |-> dq_oe == {16{!cs_n}}
      && dqs_oe == !cs_n && udqs_oe == !cs_n)
    else $error("output enables do not follow select");
  a_no_lag: assert property (ten && $changed(t) |-> $changed({dqs_c_o, dqs_t_o, dq_o}))
    else $error("outputs lag the inputs");
endmodule : pcx_ct_props
`default_nettype wire

// *** verification/testbench.sv ***
// Bench: x16 device and agent ends joined by one pin bundle.
// Drives the agent user side and the device core side at negedge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic auto_rq = 1'b1, self_rq = 1'b1, power_ok = 1'b1, calibrated = 1'b0;
  logic start = 1'b0, exit_req = 1'b0, seen, busy_seen = 1'b0;
  logic [17:0] pat_addr = 18'h00000;
  logic [1:0] pat_ba = 2'h0, pat_bg = 2'h0;
  logic [8:0] pat_ctl = 9'h000;
  logic ct_mode, clk_test, accepted, stable, vref_half, bypass;
  logic refresh_go, self_go, entry_fault, reinit, busy, done, refused;
  logic [15:0] res_dq;
  logic [3:0] res_dqs;
  int miscompares = 0, comparisons = 0, cycles = 0;

  pcx_ct_if ct_bus ();
  pcx_ct_if x4_bus ();

  // A narrow device without A17 watches the same pins through its own bundle
  assign {x4_bus.ten, x4_bus.cs_n, x4_bus.reset_n, x4_bus.cke, x4_bus.act_n, x4_bus.odt,
    x4_bus.par, x4_bus.alert_n, x4_bus.ck_t, x4_bus.ck_c, x4_bus.addr, x4_bus.ba, x4_bus.bg,
    x4_bus.dm_l_n, x4_bus.dm_u_n} = {ct_bus.ten, ct_bus.cs_n, ct_bus.reset_n, ct_bus.cke,
    ct_bus.act_n, ct_bus.odt, ct_bus.par, ct_bus.alert_n, ct_bus.ck_t, ct_bus.ck_c,
    ct_bus.addr, ct_bus.ba, ct_bus.bg, ct_bus.dm_l_n, ct_bus.dm_u_n};

  pcx_ct_device #(.DQ_WIDTH(4), .HAS_A17(1'b0)) pcx_ct_device_x4_inst (
    .clk_sys(clk_sys), .srst(srst), .pins(x4_bus.dev), .auto_refresh_req(auto_rq),
    .self_refresh_req(self_rq), .ct_mode_q(), .clk_inputs_test_q(), .inputs_accepted_q(),
    .outputs_stable_q(), .vref_half_q(), .core_bypass_q(), .refresh_go_q(),
    .self_refresh_go_q(), .entry_fault_q(), .reinit_required_q());

  pcx_ct_device #(.DQ_WIDTH(16), .HAS_A17(1'b1)) pcx_ct_device_inst (
    .clk_sys(clk_sys), .srst(srst), .pins(ct_bus.dev),
    .auto_refresh_req(auto_rq), .self_refresh_req(self_rq),
    .ct_mode_q(ct_mode), .clk_inputs_test_q(clk_test), .inputs_accepted_q(accepted),
    .outputs_stable_q(stable), .vref_half_q(vref_half), .core_bypass_q(bypass),
    .refresh_go_q(refresh_go), .self_refresh_go_q(self_go),
    .entry_fault_q(entry_fault), .reinit_required_q(reinit));

  pcx_ct_agent #(.DQ_WIDTH(16)) pcx_ct_agent_inst (
    .clk_sys(clk_sys), .srst(srst), .pins(ct_bus.agent),
    .power_ok(power_ok), .device_calibrated(calibrated), .start(start),
    .exit_req(exit_req), .pat_addr(pat_addr), .pat_ba(pat_ba), .pat_bg(pat_bg),
    .pat_ctl(pat_ctl), .busy_q(busy), .done_q(done), .refused_q(refused),
    .res_dq_q(res_dq), .res_dqs_q(res_dqs));

  pcx_ct_props pcx_ct_props_inst (
    .clk_sys(clk_sys), .srst(srst), .ten(ct_bus.ten), .cs_n(ct_bus.cs_n),
    .reset_n(ct_bus.reset_n), .cke(ct_bus.cke), .act_n(ct_bus.act_n), .odt(ct_bus.odt),
    .par(ct_bus.par), .alert_n(ct_bus.alert_n), .ck_t(ct_bus.ck_t), .ck_c(ct_bus.ck_c),
    .addr(ct_bus.addr), .ba(ct_bus.ba), .bg(ct_bus.bg), .dm_l_n(ct_bus.dm_l_n),
    .dm_u_n(ct_bus.dm_u_n), .dq_o(ct_bus.dq_o), .dq_oe(ct_bus.dq_oe),
    .dqs_t_o(ct_bus.dqs_t_o), .dqs_c_o(ct_bus.dqs_c_o), .dqs_oe(ct_bus.dqs_oe),
    .udqs_t_o(ct_bus.udqs_t_o), .udqs_c_o(ct_bus.udqs_c_o), .udqs_oe(ct_bus.udqs_oe));

  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  // Expected terms; v is {ctl, bg, ba, addr}, test mode with RESET_n high
  function automatic logic [9:0] terms(input logic [30:0] v);
    logic [17:0] a;
    logic [8:0] c;
    a = v[17:0];
    c = v[30:22];
    terms[0] = a[1] ^ a[6] ^ c[3];
    terms[1] = a[8] ^ c[4] ^ a[9];
    terms[2] = a[2] ^ a[5] ^ a[13] ^ a[17];
    terms[3] = a[0] ^ a[7] ^ a[11];
    terms[4] = c[6] ^ c[2] ^ a[15];
    terms[5] = c[0] ^ a[16] ^ a[10];
    terms[6] = c[1] ^ a[4] ^ v[19];
    terms[7] = c[8] ^ c[7] ^ c[5];
    terms[8] = a[14] ^ a[12] ^ v[18];
    terms[9] = v[20] ^ a[3] ^ 1'b1;
  endfunction : terms

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One pattern: start, wait for done, compare captured and live pins
  task automatic apply(input logic [30:0] v);
    int n;
    logic [9:0] t;
    t = terms(v);
    {pat_ctl, pat_bg, pat_ba, pat_addr} = v;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    check("done", 16'h0001, {15'h0000, done});
    check("res_dq", {~t[7:0], t[7:0]}, res_dq);
    check("res_dqs", {12'h000, ~t[9:8], t[9:8]}, {12'h000, res_dqs});
    check("dq_pins", {~t[7:0], t[7:0]}, ct_bus.dq_o);
    check("dq_oe", 16'hFFFF, ct_bus.dq_oe);
    // Narrow device: pairs of terms, term 7 without mask, term 2 without A17
    check("x4_dq", {12'h000, t[6] ^ v[21] ^ v[27], t[5] ^ t[4], t[3] ^ t[2] ^ v[17],
      t[1] ^ t[0]}, x4_bus.dq_o);
    check("x4_dqs", {12'h001, t[9:8]}, {12'h000, x4_bus.udqs_oe, x4_bus.dqs_oe,
      x4_bus.dqs_c_o, x4_bus.dqs_t_o});
    check("x4_oe", 16'h000F, x4_bus.dq_oe);
  endtask : apply

  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    repeat (6) @(negedge clk_sys);
    srst = 1'b0;
    repeat (4) @(negedge clk_sys);
    check("oe_idle", 16'h0000, ct_bus.dq_oe);
    check("refresh_idle", 16'h0003, {14'h0000, self_go, refresh_go});
    // Start after calibration is turned away
    calibrated = 1'b1;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    seen = refused;
    repeat (3) begin
      @(negedge clk_sys);
      seen = seen | refused;
    end
    check("refused", 16'h0001, {15'h0000, seen});
    check("ten_refused", 16'h0000, {15'h0000, ct_bus.ten});
    calibrated = 1'b0;
    // Zero, every single input bit, then all ones
    for (int i = 0; i <= 32; i++) begin
      apply(i == 0 ? 31'h00000000 : (i == 32 ? 31'h7FFFFFFF : 31'h1 << (i - 1)));
    end
    check("status", 16'h003F, {10'h000, ct_mode, clk_test, accepted, stable, vref_half,
      bypass});
    check("refresh_test", 16'h0000, {14'h0000, self_go, refresh_go});
    check("entry_fault", 16'h0000, {15'h0000, entry_fault});
    // Leave test mode; reset must be flagged as needed
    exit_req = 1'b1;
    @(negedge clk_sys);
    exit_req = 1'b0;
    seen = reinit;
    repeat (30) begin
      @(negedge clk_sys);
      seen = seen | reinit;
      busy_seen = busy_seen | busy;
    end
    check("reinit_seen", 16'h0001, {15'h0000, seen});
    check("busy_seen", 16'h0001, {15'h0000, busy_seen});
    check("busy_idle", 16'h0000, {15'h0000, busy});
    check("mode_off", 16'h0000, {15'h0000, ct_mode});
    check("oe_off", 16'h0000, ct_bus.dq_oe);
    final_report();
  end
endmodule : testbench
`default_nettype wire
